// ### rtl/cmt_comparator2_ctrl.sv
// comparator two control, pin output, port read and timer gate, with AXI4-Lite slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cmt_params.svh"

module cmt_comparator2_ctrl (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic [`CMT_ADDR_W-1:0] awaddr,
	input  wire logic                   awvalid,
	output      logic                   awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output      logic                   wready,
	output      logic [1:0]             bresp,
	output      logic                   bvalid,
	input  wire logic                   bready,
	input  wire logic [`CMT_ADDR_W-1:0] araddr,
	input  wire logic                   arvalid,
	output      logic                   arready,
	output      logic [31:0]            rdata,
	output      logic [1:0]             rresp,
	output      logic                   rvalid,
	input  wire logic                   rready,
	input  wire logic [`CMT_LVL_W-1:0]  cmp2PlusPin,
	input  wire logic [`CMT_LVL_W-1:0]  sharedMinusPinZero,
	input  wire logic [`CMT_LVL_W-1:0]  sharedMinusPinOne,
	input  wire logic [`CMT_LVL_W-1:0]  sharedMinusPinTwo,
	input  wire logic [`CMT_LVL_W-1:0]  sharedMinusPinThree,
	input  wire logic [`CMT_LVL_W-1:0]  programmableReference,
	input  wire logic [`CMT_LVL_W-1:0]  fixedReference,
	input  wire logic [`CMT_PORT_W-1:0] portPins,
	input  wire logic                   tmrClkPin,
	input  wire logic                   extGatePin,
	output      logic                   cmp2PinOut,
	output      logic                   cmp2PinOe,
	output      logic [`CMT_CNT_W-1:0]  tmrCount
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [`CMT_LVL_W-1:0] selLevel(
		input logic                  sel,
		input logic [`CMT_LVL_W-1:0] whenSet,
		input logic [`CMT_LVL_W-1:0] whenClear
	);
		selLevel = sel ? whenSet : whenClear;
	endfunction

	function automatic logic [`CMT_LVL_W-1:0] selMinus(
		input logic [1:0]            ch,
		input logic [`CMT_LVL_W-1:0] m0,
		input logic [`CMT_LVL_W-1:0] m1,
		input logic [`CMT_LVL_W-1:0] m2,
		input logic [`CMT_LVL_W-1:0] m3
	);
		unique case (ch)
			2'h0: selMinus = m0;
			2'h1: selMinus = m1;
			2'h2: selMinus = m2;
			2'h3: selMinus = m3;
		endcase
	endfunction

	function automatic logic isMapped(input logic [`CMT_ADDR_W-1:0] addr);
		unique case (addr)
			`CMT_OFF_CTRL,
			`CMT_OFF_SHARED,
			`CMT_OFF_DIR,
			`CMT_OFF_ANALOG,
			`CMT_OFF_PORT,
			`CMT_OFF_TMRCTL,
			`CMT_OFF_TMRCNT: isMapped = 1'b1;
			default:         isMapped = 1'b0;
		endcase
	endfunction

	// ****************************************
	// state and inputs
	// ****************************************
	cmt_pkg::cmt_top_t         q;
	cmt_pkg::cmt_top_t         d;
	logic [`CMT_SYNC_W-1:0]    pinSync;
	logic [`CMT_LVL_W-1:0]     refLevel;
	logic [`CMT_LVL_W-1:0]     plusLevel;
	logic [`CMT_LVL_W-1:0]     minusLevel;
	logic [7:0]                ctrlRead;
	logic [7:0]                sharedRead;
	logic [31:0]               rdWord;

	// pins arrive asynchronously; analog levels are already clk-sampled codes
	cmt_sync u_sync (
		.clk  (clk),
		.nrst (nrst),
		.din  ({extGatePin, tmrClkPin, portPins}),
		.dout (pinSync)
	);

	// ****************************************
	// comparator, pin and register file
	// ****************************************
	always_comb begin
		d          = q;
		refLevel   = selLevel(q.shared[`CMT_SH_REFSEL], programmableReference,
			fixedReference);
		plusLevel  = selLevel(q.ctrl[`CMT_CTRL_PSEL], refLevel, cmp2PlusPin);
		minusLevel = selMinus(q.ctrl[`CMT_CTRL_CH_HI:`CMT_CTRL_CH_LO], sharedMinusPinZero,
			sharedMinusPinOne, sharedMinusPinTwo, sharedMinusPinThree);
		// a disabled comparator reports low whatever the polarity
		d.result   = q.ctrl[`CMT_CTRL_EN] &
			((plusLevel > minusLevel) ^ q.ctrl[`CMT_CTRL_INV]);
		d.pinOe    = q.ctrl[`CMT_CTRL_DRV] & q.ctrl[`CMT_CTRL_EN] &
			~q.dir[`CMT_CMP_PIN];
		d.pinOut   = d.pinOe & d.result;

		ctrlRead                  = q.ctrl;
		ctrlRead[`CMT_CTRL_RES]   = q.result;
		sharedRead                = q.shared;
		sharedRead[`CMT_SH_MIRROR2] = q.result;
		rdWord                    = 32'h0000_0000;
		unique case (araddr)
			`CMT_OFF_CTRL:   rdWord[7:0] = ctrlRead;
			`CMT_OFF_SHARED: rdWord[7:0] = sharedRead;
			`CMT_OFF_DIR:    rdWord[7:0] = q.dir;
			`CMT_OFF_ANALOG: rdWord[7:0] = q.analog;
			`CMT_OFF_PORT:   rdWord[7:0] = pinSync[`CMT_PORT_W-1:0] & ~q.analog;
			`CMT_OFF_TMRCNT: rdWord[`CMT_CNT_W-1:0] = tmrCount;
			`CMT_OFF_TMRCTL: rdWord[7:0] = q.tmrCtl;
			default:         rdWord = 32'h0000_0000;
		endcase

		// write channel: address and data taken independently
		if (awvalid && q.awReady) begin
			d.awHave = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && q.wReady) begin
			d.wHave = 1'b1;
			d.wData = wdata[7:0];
			d.wLane = wstrb[0];
		end
		if (q.bValid && bready) begin
			d.bValid = 1'b0;
		end
		if (q.awHave && q.wHave && !q.bValid) begin
			d.awHave = 1'b0;
			d.wHave  = 1'b0;
			d.bValid = 1'b1;
			d.bResp  = isMapped(q.awAddr) ? `CMT_RESP_OKAY : `CMT_RESP_SLVERR;
			if (q.wLane) begin
				unique case (q.awAddr)
					`CMT_OFF_CTRL:   d.ctrl   = q.wData & `CMT_CTRL_WMASK;
					`CMT_OFF_SHARED: d.shared = q.wData & `CMT_SH_WMASK;
					`CMT_OFF_DIR:    d.dir    = q.wData;
					`CMT_OFF_ANALOG: d.analog = q.wData;
					`CMT_OFF_TMRCTL: d.tmrCtl = q.wData & `CMT_TMR_WMASK;
					default:         d.ctrl   = q.ctrl;
				endcase
			end
		end
		d.awReady = ~d.awHave & ~d.bValid;
		d.wReady  = ~d.wHave & ~d.bValid;

		// read channel: one read in flight, data registered at acceptance
		if (q.rValid && rready) begin
			d.rValid = 1'b0;
		end
		if (arvalid && q.arReady) begin
			d.rValid = 1'b1;
			d.rData  = rdWord;
			d.rResp  = isMapped(araddr) ? `CMT_RESP_OKAY : `CMT_RESP_SLVERR;
		end
		d.arReady = ~d.rValid;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q         <= '0;
			q.ctrl    <= `CMT_CTRL_RST;
			q.shared  <= `CMT_SH_RST;
			q.dir     <= `CMT_DIR_RST;
			q.analog  <= `CMT_ANALOG_RST;
			q.tmrCtl  <= `CMT_TMR_RST;
			q.awReady <= 1'b1;
			q.wReady  <= 1'b1;
			q.arReady <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// timer gate
	// ****************************************
	cmt_gate_timer u_timer (
		.clk        (clk),
		.nrst       (nrst),
		.tmrClk     (pinSync[`CMT_PORT_W]),
		.tmrOn      (q.tmrCtl[`CMT_TMR_ON]),
		.gateEnable (q.tmrCtl[`CMT_TMR_GATE]),
		.presc      (q.tmrCtl[`CMT_TMR_PS_HI:`CMT_TMR_PS_LO]),
		.gateSelect (q.shared[`CMT_SH_GSS]),
		.syncEnable (q.shared[`CMT_SH_SYNC]),
		.cmpResult  (q.result),
		.extGate    (pinSync[`CMT_PORT_W+1]),
		.count      (tmrCount),
		.syncedOut  ()
	);

	assign awready    = q.awReady;
	assign wready     = q.wReady;
	assign bvalid     = q.bValid;
	assign bresp      = q.bResp;
	assign arready    = q.arReady;
	assign rvalid     = q.rValid;
	assign rdata      = q.rData;
	assign rresp      = q.rResp;
	assign cmp2PinOut = q.pinOut;
	assign cmp2PinOe  = q.pinOe;

	// ****************************************
	// checks
	// ****************************************
	pin_drive_a: assert property (@(posedge clk) disable iff (!nrst)
		1'b1 |=> cmp2PinOe == $past(q.ctrl[`CMT_CTRL_DRV] && q.ctrl[`CMT_CTRL_EN] &&
			!q.dir[`CMT_CMP_PIN]))
		else $error("pin enable does not follow drive, enable and direction");

	pin_value_a: assert property (@(posedge clk) disable iff (!nrst)
		cmp2PinOe |-> cmp2PinOut == q.result)
		else $error("driven pin differs from comparator result");

	result_off_a: assert property (@(posedge clk) disable iff (!nrst)
		!q.ctrl[`CMT_CTRL_EN] |=> !q.result)
		else $error("disabled comparator reports high");

	polarity_a: assert property (@(posedge clk) disable iff (!nrst)
		q.ctrl[`CMT_CTRL_EN] |=> q.result == $past((plusLevel > minusLevel) ^
			q.ctrl[`CMT_CTRL_INV]))
		else $error("result polarity wrong");

	channel_three_a: assert property (@(posedge clk) disable iff (!nrst)
		(q.ctrl[`CMT_CTRL_EN] && q.ctrl[1:0] == 2'h3 && !q.ctrl[`CMT_CTRL_PSEL] &&
			!q.ctrl[`CMT_CTRL_INV]) |=> q.result == $past(cmp2PlusPin > sharedMinusPinThree))
		else $error("channel three not compared against minus pin three");

	ref_select_a: assert property (@(posedge clk) disable iff (!nrst)
		(q.ctrl[`CMT_CTRL_EN] && q.ctrl[1:0] == 2'h0 && q.ctrl[`CMT_CTRL_PSEL] &&
			q.shared[`CMT_SH_REFSEL] && !q.ctrl[`CMT_CTRL_INV])
		|=> q.result == $past(programmableReference > sharedMinusPinZero))
		else $error("plus input not taken from programmable reference");

	port_read_a: assert property (@(posedge clk) disable iff (!nrst)
		(arvalid && arready && araddr == `CMT_OFF_PORT)
		|=> rvalid && ((rdata[7:0] & $past(q.analog)) == 8'h00))
		else $error("analog pin read back nonzero");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		(arvalid && arready && araddr == `CMT_OFF_CTRL)
		|=> rdata[`CMT_CTRL_RSVD] == 1'b0 && rdata[31:8] == 24'h000000)
		else $error("reserved control bits read nonzero");

	plus_pin_a: assert property (@(posedge clk) disable iff (!nrst)
		(q.ctrl[`CMT_CTRL_EN] && q.ctrl[1:0] == 2'h0 && !q.ctrl[`CMT_CTRL_PSEL] &&
			!q.ctrl[`CMT_CTRL_INV]) |=> q.result == $past(cmp2PlusPin > sharedMinusPinZero))
		else $error("plus input not taken from the plus pin");

	ref_fixed_a: assert property (@(posedge clk) disable iff (!nrst)
		(q.ctrl[`CMT_CTRL_EN] && q.ctrl[1:0] == 2'h0 && q.ctrl[`CMT_CTRL_PSEL] &&
			!q.shared[`CMT_SH_REFSEL] && !q.ctrl[`CMT_CTRL_INV])
		|=> q.result == $past(fixedReference > sharedMinusPinZero))
		else $error("plus input not taken from fixed reference");

	channel_one_a: assert property (@(posedge clk) disable iff (!nrst)
		(q.ctrl[`CMT_CTRL_EN] && q.ctrl[1:0] == 2'h1 && !q.ctrl[`CMT_CTRL_PSEL] &&
			!q.ctrl[`CMT_CTRL_INV]) |=> q.result == $past(cmp2PlusPin > sharedMinusPinOne))
		else $error("channel one not compared against minus pin one");

	pin_internal_a: assert property (@(posedge clk) disable iff (!nrst)
		!q.ctrl[`CMT_CTRL_DRV] |=> !cmp2PinOe && !cmp2PinOut)
		else $error("pin driven while drive enable is clear");

	ctrl_fixed_bits_a: assert property (@(posedge clk) disable iff (!nrst)
		q.ctrl[`CMT_CTRL_RES] == 1'b0 && q.ctrl[`CMT_CTRL_RSVD] == 1'b0)
		else $error("read-only control bits were written");

endmodule

// ### rtl/cmt_gate_timer.sv
// prescaler, synchronising latch and gated 16-bit counter
`timescale 1ns/100ps
`include "cmt_params.svh"

module cmt_gate_timer (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  tmrClk,
	input  wire logic                  tmrOn,
	input  wire logic                  gateEnable,
	input  wire logic [1:0]            presc,
	input  wire logic                  gateSelect,
	input  wire logic                  syncEnable,
	input  wire logic                  cmpResult,
	input  wire logic                  extGate,
	output      logic [`CMT_CNT_W-1:0] count,
	output      logic                  syncedOut
);

	cmt_pkg::cmt_tmr_t q;
	cmt_pkg::cmt_tmr_t d;
	logic              pLevel;
	logic              pRise;
	logic              pFall;
	logic              gate;

	always_comb begin
		d = q;
		unique case (presc)
			2'h0: pLevel = tmrClk;
			2'h1: pLevel = q.prescCnt[0];
			2'h2: pLevel = q.prescCnt[1];
			2'h3: pLevel = q.prescCnt[2];
		endcase
		d.tclkPrev = tmrClk;
		if (tmrOn && tmrClk && !q.tclkPrev) begin
			d.prescCnt = q.prescCnt + 3'h1;
		end
		pRise   = pLevel && !q.pPrev;
		pFall   = !pLevel && q.pPrev;
		d.pPrev = pLevel;
		// latch after the prescaler, on its falling edge
		if (pFall) begin
			d.synced = cmpResult;
		end
		// unlatched path when synchronisation is off
		gate = gateSelect ? extGate : (syncEnable ? q.synced : cmpResult);
		// counting on the rising edge keeps it clear of the latch edge
		if (tmrOn && pRise && (!gateEnable || gate)) begin
			d.count = q.count + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign count     = q.count;
	assign syncedOut = q.synced;

	count_rise_a: assert property (@(posedge clk) disable iff (!nrst)
		$changed(q.count) |-> $past(pRise) && $past(tmrOn))
		else $error("counter moved without a rising timer clock");

	count_gated_a: assert property (@(posedge clk) disable iff (!nrst)
		(tmrOn && pRise && gateEnable && !gateSelect && !syncEnable && !cmpResult)
		|=> $stable(q.count))
		else $error("counter moved while comparator gate was closed");

	sync_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		(tmrOn && pRise && gateEnable && !gateSelect && syncEnable && q.synced)
		|=> q.count == $past(q.count) + 16'h0001)
		else $error("synced gate open but counter did not step");

	latch_fall_a: assert property (@(posedge clk) disable iff (!nrst)
		$changed(q.synced) |-> $past(pFall))
		else $error("sync latch changed off the prescaled falling edge");

endmodule

// ### rtl/cmt_params.svh
// offsets, field positions, reset values and widths of the comparator two block
`ifndef CMT_PARAMS_SVH
`define CMT_PARAMS_SVH

// ****************************************
// widths
// ****************************************
`define CMT_ADDR_W      8
`define CMT_LVL_W       8
`define CMT_PORT_W      8
`define CMT_SYNC_W      10
`define CMT_CNT_W       16

// ****************************************
// register byte offsets
// ****************************************
`define CMT_OFF_CTRL    8'h00
`define CMT_OFF_SHARED  8'h04
`define CMT_OFF_DIR     8'h08
`define CMT_OFF_ANALOG  8'h0c
`define CMT_OFF_PORT    8'h10
`define CMT_OFF_TMRCTL  8'h14
`define CMT_OFF_TMRCNT  8'h18

// ****************************************
// comparator_two_control fields
// ****************************************
`define CMT_CTRL_EN     7
`define CMT_CTRL_RES    6
`define CMT_CTRL_DRV    5
`define CMT_CTRL_INV    4
`define CMT_CTRL_RSVD   3
`define CMT_CTRL_PSEL   2
`define CMT_CTRL_CH_HI  1
`define CMT_CTRL_CH_LO  0
`define CMT_CTRL_WMASK  8'hb7
`define CMT_CTRL_RST    8'h00

// ****************************************
// shared_comparator_control fields
// ****************************************
`define CMT_SH_MIRROR2  6
`define CMT_SH_REFSEL   4
`define CMT_SH_GSS      1
`define CMT_SH_SYNC     0
`define CMT_SH_WMASK    8'h33
`define CMT_SH_RST      8'h02

// ****************************************
// port and timer control
// ****************************************
`define CMT_CMP_PIN     5
`define CMT_DIR_RST     8'hff
`define CMT_ANALOG_RST  8'hff
`define CMT_TMR_ON      0
`define CMT_TMR_GATE    1
`define CMT_TMR_PS_HI   3
`define CMT_TMR_PS_LO   2
`define CMT_TMR_WMASK   8'h0f
`define CMT_TMR_RST     8'h00

// ****************************************
// bus responses
// ****************************************
`define CMT_RESP_OKAY   2'h0
`define CMT_RESP_SLVERR 2'h2

`endif

// ### rtl/cmt_pkg.sv
// state types of the comparator two block
package cmt_pkg;
`include "cmt_params.svh"

	typedef struct packed {
		logic [`CMT_SYNC_W-1:0] first;
		logic [`CMT_SYNC_W-1:0] second;
	} cmt_sync_t;

	typedef struct packed {
		logic                  tclkPrev;
		logic [2:0]            prescCnt;
		logic                  pPrev;
		logic                  synced;
		logic [`CMT_CNT_W-1:0] count;
	} cmt_tmr_t;

	typedef struct packed {
		logic [7:0]             ctrl;
		logic [7:0]             shared;
		logic [7:0]             dir;
		logic [7:0]             analog;
		logic [7:0]             tmrCtl;
		logic                   result;
		logic                   pinOut;
		logic                   pinOe;
		logic                   awHave;
		logic [`CMT_ADDR_W-1:0] awAddr;
		logic                   wHave;
		logic [7:0]             wData;
		logic                   wLane;
		logic                   awReady;
		logic                   wReady;
		logic                   bValid;
		logic [1:0]             bResp;
		logic                   arReady;
		logic                   rValid;
		logic [31:0]            rData;
		logic [1:0]             rResp;
	} cmt_top_t;

endpackage

// ### rtl/cmt_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/100ps
`include "cmt_params.svh"

module cmt_sync (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic [`CMT_SYNC_W-1:0] din,
	output      logic [`CMT_SYNC_W-1:0] dout
);

	cmt_pkg::cmt_sync_t q;
	cmt_pkg::cmt_sync_t d;

	// first stage feeds only the second stage
	always_comb begin
		d        = q;
		d.first  = din;
		d.second = q.first;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dout = q.second;

endmodule

// ### testbench/cmt_tclk_src.sv
// timer clock source model standing at the far side of the gated counter
`timescale 1ns/100ps

module cmt_tclk_src (
	input  wire logic clk,
	output      logic tmrClk
);
	// ****************************************
	// edge tasks
	// ****************************************
	// idles low between bursts; each level is held long enough for the pin synchroniser
	initial begin
		tmrClk = 1'b0;
	end

	task automatic rise();
		@(posedge clk);
		tmrClk <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic fall();
		@(posedge clk);
		tmrClk <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			rise();
			fall();
		end
	endtask
endmodule

// ### testbench/comparator2_control_timer_gate_tb_top.sv
// self-checking bench of the comparator two control and timer gate block
`timescale 1ns/100ps
`include "cmt_params.svh"

module comparator2_control_timer_gate_tb_top;
	// ****************************************
	// stimulus signals
	// ****************************************
	logic        clk      = 1'b0;
	logic        nrst     = 1'b0;
	logic [7:0]  awaddr   = 8'h00;
	logic        awvalid  = 1'b0;
	logic [31:0] wdata    = 32'h00000000;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic [7:0]  araddr   = 8'h00;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic [7:0]  plusLvl  = 8'h70;
	logic [7:0]  mLvl [4] = '{8'h40, 8'h60, 8'h80, 8'ha0};
	logic [7:0]  progRef  = 8'h90;
	logic [7:0]  fixRef   = 8'h50;
	logic [7:0]  portLvl  = 8'h5a;
	logic        extGate  = 1'b0;
	logic        tmrClk;
	logic        awready, wready, bvalid, arready, rvalid, pinOut, pinOe;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] tmrCount;
	int          nMismatch = 0;
	int          checks    = 0;

	always #5 clk = ~clk;

	cmt_comparator2_ctrl u_dut (
		.clk(clk), .nrst(nrst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cmp2PlusPin(plusLvl), .sharedMinusPinZero(mLvl[0]), .sharedMinusPinOne(mLvl[1]),
		.sharedMinusPinTwo(mLvl[2]), .sharedMinusPinThree(mLvl[3]),
		.programmableReference(progRef), .fixedReference(fixRef),
		.portPins(portLvl), .tmrClkPin(tmrClk), .extGatePin(extGate),
		.cmp2PinOut(pinOut), .cmp2PinOe(pinOe), .tmrCount(tmrCount)
	);

	cmt_tclk_src u_src (
		.clk(clk),
		.tmrClk(tmrClk)
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic wrap_up();
		if (nMismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			nMismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h000000, d};
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rd(`CMT_OFF_CTRL, d, r);
		chk(d, 32'h00000000);
		rd(`CMT_OFF_SHARED, d, r);
		chk(d, 32'h00000002);
		wr(8'h1c, 8'hff, r);
		chk({30'h0, r}, {30'h0, `CMT_RESP_SLVERR});
		rd(8'h1c, d, r);
		chk({d[29:0], r}, {30'h0, `CMT_RESP_SLVERR});
	endtask

	task automatic t_cmp();
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  pv;
		logic        res;
		for (int i = 0; i < 32; i++) begin
			wr(`CMT_OFF_SHARED, {3'b000, i[3], 4'b0010}, r);
			wr(`CMT_OFF_CTRL, {3'b100, i[4], 1'b0, i[2:0]}, r);
			pv = i[2] ? (i[3] ? progRef : fixRef) : plusLvl;
			res = (pv > mLvl[i[1:0]]) ^ i[4];
			rd(`CMT_OFF_CTRL, d, r);
			chk(d, {24'h0, 1'b1, res, 1'b0, i[4], 1'b0, i[2:0]});
			rd(`CMT_OFF_SHARED, d, r);
			chk(d, {24'h0, 1'b0, res, 1'b0, i[3], 4'b0010});
		end
	endtask

	task automatic t_bits();
		logic [31:0] d;
		logic [1:0]  r;
		wr(`CMT_OFF_CTRL, 8'h4b, r);
		rd(`CMT_OFF_CTRL, d, r);
		chk(d, 32'h00000003);
		// inverted with plus below minus would read one if the comparator were on
		wr(`CMT_OFF_CTRL, 8'h12, r);
		rd(`CMT_OFF_CTRL, d, r);
		chk(d, 32'h00000012);
	endtask

	task automatic t_pin();
		logic [1:0] r;
		logic       oe;
		for (int j = 0; j < 16; j++) begin
			wr(`CMT_OFF_DIR, {2'b11, j[2], 5'h1f}, r);
			wr(`CMT_OFF_CTRL, {j[1], 1'b0, j[0], j[3], 4'h0}, r);
			repeat (3) @(posedge clk);
			oe = j[0] & j[1] & ~j[2];
			chk({31'h0, pinOe}, {31'h0, oe});
			if (oe) chk({31'h0, pinOut}, {31'h0, ~j[3]});
		end
	endtask

	task automatic t_port();
		logic [31:0] d;
		logic [1:0]  r;
		wr(`CMT_OFF_ANALOG, 8'h0f, r);
		rd(`CMT_OFF_PORT, d, r);
		chk(d, 32'h00000050);
		wr(`CMT_OFF_ANALOG, 8'hff, r);
		rd(`CMT_OFF_PORT, d, r);
		chk(d, 32'h00000000);
		wr(`CMT_OFF_ANALOG, 8'h00, r);
		wr(`CMT_OFF_PORT, 8'h00, r);
		rd(`CMT_OFF_PORT, d, r);
		chk(d, 32'h0000005a);
	endtask

	task automatic pulse_chk(input int n, input logic [15:0] inc);
		logic [15:0] c0;
		c0 = tmrCount;
		u_src.pulses(n);
		chk({16'h0, tmrCount}, {16'h0, c0 + inc});
	endtask

	task automatic t_gate();
		logic [1:0] r;
		wr(`CMT_OFF_CTRL, 8'h80, r);
		wr(`CMT_OFF_SHARED, 8'h00, r);
		wr(`CMT_OFF_TMRCTL, 8'h03, r);
		pulse_chk(4, 16'd4);
		wr(`CMT_OFF_CTRL, 8'h90, r);
		pulse_chk(4, 16'd0);
		wr(`CMT_OFF_SHARED, 8'h02, r);
		pulse_chk(4, 16'd0);
		extGate <= 1'b1;
		pulse_chk(4, 16'd4);
		wr(`CMT_OFF_TMRCTL, 8'h02, r);
		pulse_chk(4, 16'd0);
	endtask

	task automatic t_sync();
		logic [1:0]  r;
		logic [15:0] c0;
		// the comparator gates the counter here, so the latch is switched on
		wr(`CMT_OFF_SHARED, 8'h01, r);
		wr(`CMT_OFF_TMRCTL, 8'h03, r);
		wr(`CMT_OFF_CTRL, 8'h80, r);
		u_src.pulses(1);
		wr(`CMT_OFF_CTRL, 8'h90, r);
		c0 = tmrCount;
		u_src.rise();
		chk({16'h0, tmrCount}, {16'h0, c0 + 16'd1});
		u_src.fall();
		chk({16'h0, tmrCount}, {16'h0, c0 + 16'd1});
		u_src.rise();
		chk({16'h0, tmrCount}, {16'h0, c0 + 16'd1});
		u_src.fall();
		wr(`CMT_OFF_SHARED, 8'h00, r);
		wr(`CMT_OFF_CTRL, 8'h80, r);
		u_src.pulses(1);
		wr(`CMT_OFF_CTRL, 8'h90, r);
		c0 = tmrCount;
		u_src.rise();
		chk({16'h0, tmrCount}, {16'h0, c0});
		u_src.fall();
	endtask

	task automatic t_presc();
		logic [1:0]  r;
		logic [15:0] c0;
		wr(`CMT_OFF_SHARED, 8'h01, r);
		wr(`CMT_OFF_CTRL, 8'h80, r);
		// one full period loads the latch with the open gate before counting
		u_src.pulses(1);
		for (int k = 0; k < 4; k++) begin
			wr(`CMT_OFF_TMRCTL, {4'h0, k[1:0], 2'b11}, r);
			// moving the divider tap may itself make one edge; let it land first
			repeat (4) @(posedge clk);
			c0 = tmrCount;
			u_src.pulses(8);
			chk({16'h0, tmrCount}, {16'h0, c0 + (16'd8 >> k)});
		end
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_cmp();
		t_bits();
		t_pin();
		t_port();
		t_gate();
		t_sync();
		t_presc();
		wrap_up();
	end

	// the whole sequence needs under two thousand cycles, well under this span
	initial begin
		#100us;
		nMismatch++;
		wrap_up();
	end
endmodule
